// [design/sva_pkg.sv]
/*
 * Package for the sense-data builder and volume element address reporter.
 * Assumes a single core clock domain and an AXI4-Lite register master.
 */
package sva_pkg;
    // Register byte addresses.
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_ERR    = 8'h04;
    localparam logic [7:0] REG_PTR    = 8'h08;
    localparam logic [7:0] REG_CMD    = 8'h0c;
    localparam logic [7:0] REG_ALLOC  = 8'h10;
    localparam logic [7:0] REG_STAT   = 8'h14;
    localparam logic [7:0] REG_SENSE  = 8'h18;
    localparam logic [7:0] REG_RPT    = 8'h1c;
    localparam logic [7:0] REG_HDR0   = 8'h20;
    localparam logic [7:0] REG_HDR1   = 8'h24;
    localparam logic [7:0] REG_MATCH  = 8'h28;
    // Sense data constants.
    localparam logic [7:0] ERR_CURRENT  = 8'h70;
    localparam logic [7:0] ERR_NONE     = 8'h00;
    localparam logic [7:0] ADD_LEN      = 8'h0a;
    localparam logic [3:0] KEY_NONE     = 4'h0;
    localparam logic [3:0] KEY_NREADY   = 4'h2;
    localparam logic [3:0] KEY_HW       = 4'h4;
    localparam logic [3:0] KEY_ILLEGAL  = 4'h5;
    localparam logic [3:0] KEY_ATTN     = 4'h6;
    localparam logic [3:0] KEY_ABORT    = 4'hb;
    localparam logic [7:0] CODE_SEQ     = 8'h2c;
    localparam logic [7:0] QUAL_SEQ     = 8'h00;
    localparam logic [4:0] SENSE_LAST   = 5'h11;
    // Field positions in a sense byte 15.
    localparam int SKS_VALID_BIT = 7;
    localparam int SKS_CD_BIT    = 6;
    localparam int SKS_BPV_BIT   = 3;
    // Send volume tag action codes.
    localparam logic [4:0] ACT_TRANSLATE = 5'h05;
    // Element match table.
    localparam int          NUM_ELEM   = 32;
    localparam logic [15:0] DESC_BYTES = 16'h000c;
    localparam logic [15:0] HDR_BYTES  = 16'h0008;
    localparam logic [15:0] ELEM_LAST  = 16'h001f;
    localparam logic [1:0]  RESP_OKAY  = 2'b00;
    localparam logic [1:0]  RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SCAN = 2'b01,
        ST_DONE = 2'b10
    } sva_state_e;
endpackage

// [design/sva_core.sv]
/*
 * Sense-data builder and volume element address reporter.
 * Assumes an AXI4-Lite master on core_clk; one request of each kind at a time.
 */
// Chosen here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module sva_core
    import sva_pkg::*;
(
    // Clock and reset.
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // AXI4-Lite write channels.
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read channels.
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    // ************************************************************
    // Register state
    // ************************************************************
    logic        errPending_ff;
    logic [3:0]  senseKey_ff;
    logic [7:0]  extraErrorCode_ff;
    logic [7:0]  extraErrorQualifier_ff;
    logic        cmdData_ff;
    logic        bitIndexValid_ff;
    logic [2:0]  bitIndex_ff;
    logic [15:0] fieldIndex_ff;
    logic        fatal_ff;
    logic [7:0]  cmdByte1_ff;
    logic [15:0] startElem_ff;
    logic [15:0] numElem_ff;
    logic [23:0] allocLen_ff;
    logic        tagDone_ff;
    logic [4:0]  lastAction_ff;
    logic [NUM_ELEM-1:0] match_ff;
    logic        checkCond_ff;
    logic        goodStat_ff;
    sva_state_e  state_ff;
    logic [15:0] scanAddr_ff;
    logic [15:0] firstElem_ff;
    logic [15:0] availCnt_ff;
    logic [15:0] sentCnt_ff;
    logic [23:0] sentBytes_ff;
    logic [NUM_ELEM-1:0] reported_ff;

    // Bus handshake state.
    logic        awHeld_ff;
    logic        wHeld_ff;
    logic [7:0]  awAddr_ff;
    logic [31:0] wData_ff;
    logic [3:0]  wStrb_ff;

    logic        doWrite;
    logic        doRead;
    logic        senseRead;
    logic        startScan;
    logic        seqError;
    logic        illegalKey;
    logic [15:0] descLen;
    logic        flagHit;
    logic        inRange;
    logic [4:0]  scanIdx;

    assign s_axi_awready = !awHeld_ff && !s_axi_bvalid;
    assign s_axi_wready  = !wHeld_ff && !s_axi_bvalid;
    assign doWrite = awHeld_ff && wHeld_ff && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign doRead = s_axi_arvalid && s_axi_arready;
    assign senseRead = doRead && (s_axi_araddr == REG_SENSE);
    assign illegalKey = (senseKey_ff == KEY_ILLEGAL);
    assign startScan = doWrite && (awAddr_ff == REG_CTRL) && wData_ff[1]
                       && (state_ff != ST_SCAN);
    // Only a completed translate action arms the address report.
    assign seqError = !tagDone_ff || (lastAction_ff != ACT_TRANSLATE);
    // Tag information lengthens each descriptor.
    assign descLen = cmdByte1_ff[4] ? (DESC_BYTES + DESC_BYTES)
                                     : DESC_BYTES;
    assign scanIdx = scanAddr_ff[4:0];
    assign inRange = (scanAddr_ff <= ELEM_LAST);
    assign flagHit = inRange && match_ff[scanIdx];

    // ************************************************************
    // Write address and data capture
    // ************************************************************
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            awHeld_ff <= 1'b0;
            awAddr_ff <= 8'h00;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            awHeld_ff <= 1'b1;
            awAddr_ff <= s_axi_awaddr;
        end
        else if (doWrite)
        begin
            awHeld_ff <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wHeld_ff <= 1'b0;
            wData_ff <= 32'h0000_0000;
            wStrb_ff <= 4'h0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            wHeld_ff <= 1'b1;
            wData_ff <= s_axi_wdata;
            wStrb_ff <= s_axi_wstrb;
        end
        else if (doWrite)
        begin
            wHeld_ff <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end
        else if (doWrite)
        begin
            s_axi_bvalid <= 1'b1;
            if (awAddr_ff == REG_CTRL || awAddr_ff == REG_ERR
                || awAddr_ff == REG_PTR || awAddr_ff == REG_CMD
                || awAddr_ff == REG_ALLOC || awAddr_ff == REG_MATCH)
                s_axi_bresp <= RESP_OKAY;
            else
                s_axi_bresp <= RESP_SLVERR;
        end
        else if (s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ************************************************************
    // Stored sense condition
    // ************************************************************
    // A new error written in the same cycle as a sense read wins over
    // the clear, so no condition is lost.
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            // Reset leaves a unit attention behind for the initiator.
            errPending_ff          <= 1'b1;
            senseKey_ff            <= KEY_ATTN;
            extraErrorCode_ff      <= 8'h00;
            extraErrorQualifier_ff <= 8'h00;
            cmdData_ff             <= 1'b0;
            bitIndexValid_ff       <= 1'b0;
            bitIndex_ff            <= 3'h0;
            fieldIndex_ff          <= 16'h0000;
        end
        else if (startScan && seqError)
        begin
            errPending_ff          <= 1'b1;
            senseKey_ff            <= KEY_ILLEGAL;
            extraErrorCode_ff      <= CODE_SEQ;
            extraErrorQualifier_ff <= QUAL_SEQ;
            cmdData_ff             <= 1'b1;
            bitIndexValid_ff       <= 1'b0;
            bitIndex_ff            <= 3'h0;
            fieldIndex_ff          <= 16'h0000;
        end
        else if (doWrite && awAddr_ff == REG_ERR)
        begin
            // Key codes 2, 4, 5, 6 and 11 are stored as given.
            errPending_ff          <= (wData_ff[3:0] != KEY_NONE);
            senseKey_ff            <= wData_ff[3:0];
            extraErrorCode_ff      <= wData_ff[15:8];
            extraErrorQualifier_ff <= wData_ff[23:16];
        end
        else if (doWrite && awAddr_ff == REG_PTR)
        begin
            cmdData_ff       <= wData_ff[SKS_CD_BIT];
            bitIndexValid_ff <= wData_ff[SKS_BPV_BIT];
            bitIndex_ff      <= wData_ff[2:0];
            fieldIndex_ff    <= wData_ff[31:16];
        end
        else if (senseRead && !fatal_ff)
        begin
            errPending_ff <= 1'b0;
            senseKey_ff   <= KEY_NONE;
        end
    end

    // ************************************************************
    // Control, command block and match flags
    // ************************************************************
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fatal_ff      <= 1'b0;
            cmdByte1_ff   <= 8'h00;
            startElem_ff  <= 16'h0000;
            numElem_ff    <= 16'h0000;
            allocLen_ff   <= 24'h000000;
            tagDone_ff    <= 1'b0;
            lastAction_ff <= 5'h00;
        end
        else if (doWrite)
        begin
            if (awAddr_ff == REG_CTRL)
            begin
                fatal_ff <= wData_ff[2];
                if (wData_ff[3])
                begin
                    tagDone_ff    <= 1'b1;
                    lastAction_ff <= wData_ff[12:8];
                end
            end
            else if (awAddr_ff == REG_CMD)
            begin
                cmdByte1_ff  <= wData_ff[7:0];
                startElem_ff <= wData_ff[23:8];
                numElem_ff   <= {wData_ff[31:24], numElem_ff[7:0]};
            end
            else if (awAddr_ff == REG_ALLOC)
            begin
                allocLen_ff <= wData_ff[23:0];
                numElem_ff  <= {numElem_ff[15:8], wData_ff[31:24]};
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            match_ff <= '0;
        else if (doWrite && awAddr_ff == REG_MATCH)
            match_ff <= wData_ff;
        else if (state_ff == ST_SCAN && flagHit && reported_ff[scanIdx])
            match_ff[scanIdx] <= 1'b0;
    end

    // ************************************************************
    // Ascending element scan
    // ************************************************************
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_ff     <= ST_IDLE;
            scanAddr_ff  <= 16'h0000;
            firstElem_ff <= 16'h0000;
            availCnt_ff  <= 16'h0000;
            sentCnt_ff   <= 16'h0000;
            sentBytes_ff <= 24'h000000;
            reported_ff  <= '0;
            checkCond_ff <= 1'b0;
            goodStat_ff  <= 1'b0;
        end
        else
        begin
            case (state_ff)
                ST_IDLE, ST_DONE:
                begin
                    if (startScan)
                    begin
                        checkCond_ff <= seqError;
                        goodStat_ff  <= 1'b0;
                        availCnt_ff  <= 16'h0000;
                        sentCnt_ff   <= 16'h0000;
                        sentBytes_ff <= 24'h000000;
                        reported_ff  <= '0;
                        firstElem_ff <= 16'h0000;
                        scanAddr_ff  <= startElem_ff;
                        state_ff     <= seqError ? ST_DONE : ST_SCAN;
                    end
                end
                ST_SCAN:
                begin
                    if (!inRange || availCnt_ff == numElem_ff)
                    begin
                        goodStat_ff <= 1'b1;
                        state_ff    <= ST_DONE;
                    end
                    else
                    begin
                        // A reported element is only stepped over here.
                        if (flagHit && !reported_ff[scanIdx])
                        begin
                            if (availCnt_ff == 16'h0000)
                                firstElem_ff <= scanAddr_ff;
                            availCnt_ff <= availCnt_ff + 16'h0001;
                            // Whole descriptors only, none at length zero.
                            if ({8'h00, HDR_BYTES} + sentBytes_ff
                                + {8'h00, descLen} <= allocLen_ff)
                            begin
                                sentBytes_ff <= sentBytes_ff
                                                + {8'h00, descLen};
                                sentCnt_ff <= sentCnt_ff + 16'h0001;
                                reported_ff[scanIdx] <= 1'b1;
                            end
                        end
                        // Flags clear a cycle later, once marked reported.
                        if (!flagHit || reported_ff[scanIdx]
                            || {8'h00, HDR_BYTES} + sentBytes_ff
                               + {8'h00, descLen} > allocLen_ff)
                            scanAddr_ff <= scanAddr_ff + 16'h0001;
                    end
                end
                default:
                    state_ff <= ST_IDLE;
            endcase
        end
    end

    // ************************************************************
    // Read data
    // ************************************************************
    logic [31:0] rdMux;
    logic [1:0]  rdResp;
    logic [7:0]  errCode;

    assign errCode = errPending_ff ? ERR_CURRENT : ERR_NONE;

    always_comb
    begin
        rdMux  = 32'h0000_0000;
        rdResp = RESP_OKAY;
        if (s_axi_araddr == REG_CTRL)
            rdMux = {19'h0, lastAction_ff, 5'h00, fatal_ff, 1'b0, 1'b0};
        else if (s_axi_araddr == REG_ERR)
            rdMux = {8'h00, extraErrorQualifier_ff, extraErrorCode_ff,
                     4'h0, senseKey_ff};
        else if (s_axi_araddr == REG_PTR || s_axi_araddr == REG_SENSE)
            // Byte 15 and field pointer bytes 16-17; the specific part is
            // valid only under an illegal request key.
            rdMux = {fieldIndex_ff, 8'h00,
                     illegalKey, cmdData_ff & illegalKey, 1'b0, 1'b0,
                     bitIndexValid_ff & illegalKey,
                     bitIndex_ff};
        else if (s_axi_araddr == REG_CMD)
            rdMux = {numElem_ff[15:8], startElem_ff, cmdByte1_ff};
        else if (s_axi_araddr == REG_ALLOC)
            rdMux = {numElem_ff[7:0], allocLen_ff};
        else if (s_axi_araddr == REG_STAT)
            rdMux = {22'h0, tagDone_ff, 3'h0, errCode[6], 1'b0,
                     goodStat_ff, checkCond_ff, state_ff};
        else if (s_axi_araddr == REG_RPT)
            rdMux = {sentCnt_ff, 8'h00, ADD_LEN};
        else if (s_axi_araddr == REG_HDR0)
            rdMux = {availCnt_ff, firstElem_ff};
        else if (s_axi_araddr == REG_HDR1)
            rdMux = {8'h00, 16'(availCnt_ff * descLen), 3'h0,
                     lastAction_ff};
        else if (s_axi_araddr == REG_MATCH)
            rdMux = match_ff;
        else
            rdResp = RESP_SLVERR;
    end

    // The sense word packs error code, key byte (segment zero, flags zero)
    // and the joint code and qualifier; info fields are never stored.
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
        end
        else if (doRead)
        begin
            s_axi_rvalid <= 1'b1;
            if (senseRead)
            begin
                // Fatal error answers with an error response.
                s_axi_rresp <= fatal_ff ? RESP_SLVERR : RESP_OKAY;
                s_axi_rdata <= {errCode, 4'h0, senseKey_ff,
                                extraErrorCode_ff,
                                extraErrorQualifier_ff};
            end
            else
            begin
                s_axi_rresp <= rdResp;
                s_axi_rdata <= rdMux;
            end
        end
        else if (s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule // sva_core
`default_nettype wire

// [tb/sva_core_assertions.sv]
/* Bus-port assertions for sva_core, bound to every instance.
   Assumes the register map of sva_pkg and a single clock. */
`timescale 1ns/1ps
`default_nettype none
module sva_core_assertions
    import sva_pkg::*;
(
    // Clock, reset and bus.
    input wire logic        core_clk, rst_n,
    input wire logic [7:0]  s_axi_awaddr, s_axi_araddr,
    input wire logic [31:0] s_axi_wdata, s_axi_rdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic [1:0]  s_axi_bresp, s_axi_rresp,
    input wire logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid,
    input wire logic        s_axi_wready, s_axi_bvalid, s_axi_bready,
    input wire logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid,
    input wire logic        s_axi_rready
);
    // ********
    // Checks
    // ********
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic arTake;
    assign arTake = s_axi_arvalid && s_axi_arready;
    a_sense_form: assert property (
        arTake && s_axi_araddr == REG_SENSE |=> s_axi_rresp != RESP_OKAY ||
        (s_axi_rdata[23:20] == 4'h0 && s_axi_rdata[31:24] ==
        (s_axi_rdata[19:16] != 4'h0 ? ERR_CURRENT : ERR_NONE)))
        else $error("sense word malformed");
    a_add_len: assert property (
        arTake && s_axi_araddr == REG_RPT |=> s_axi_rdata[7:0] == ADD_LEN)
        else $error("additional length wrong");
    a_ptr_form: assert property (
        arTake && s_axi_araddr == REG_PTR |=>
        s_axi_rdata[15:8] == 8'h00 && !s_axi_rdata[5])
        else $error("pointer word malformed");
    a_hdr_form: assert property (
        arTake && s_axi_araddr == REG_HDR1 |=> s_axi_rdata[7:5] == 3'h0)
        else $error("header action byte malformed");
    a_mapped_okay: assert property (
        arTake && s_axi_araddr <= REG_MATCH && s_axi_araddr[1:0] == 2'h0 &&
        s_axi_araddr != REG_SENSE |=> s_axi_rresp == RESP_OKAY)
        else $error("mapped read refused");
    a_read_answer: assert property (arTake |=> s_axi_rvalid)
        else $error("read answer late");
    a_r_hold: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid &&
        $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read answer dropped");
    a_b_after: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
    c_sense: cover property (arTake && s_axi_araddr == REG_SENSE);
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_refuse: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule // sva_core_assertions
bind sva_core sva_core_assertions sva_core_assertions_inst (.*);
`default_nettype wire

// [tb/sva_mst.sv]
/* Register-bus master standing in for the initiator's adapter.
   Assumes the bench calls one task at a time. */
`timescale 1ns/1ps
`default_nettype none
module sva_mst
(
    // Clock and slave answers.
    input wire logic        core_clk,
    input wire logic        s_axi_awready, s_axi_wready, s_axi_bvalid,
    input wire logic        s_axi_arready, s_axi_rvalid,
    input wire logic [1:0]  s_axi_bresp, s_axi_rresp,
    input wire logic [31:0] s_axi_rdata,
    // Requests.
    output logic [7:0]      s_axi_awaddr, s_axi_araddr,
    output logic [31:0]     s_axi_wdata,
    output logic [3:0]      s_axi_wstrb,
    output logic            s_axi_awvalid, s_axi_wvalid, s_axi_bready,
    output logic            s_axi_arvalid, s_axi_rready
);
    // ********
    // Bus cycles
    // ********
    initial
    begin
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready} = '0;
    end
    // Payload is inverted after the answer so stale values never match.
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge core_clk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        s_axi_awaddr <= ~a;
        s_axi_wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
            @(posedge core_clk);
        while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
        do
            @(posedge core_clk);
        while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
endmodule // sva_mst
`default_nettype wire

// [tb/tb.sv]
/* Self-checking bench for sva_core driven through sva_mst.
   Assumes the checker is bound to the core. */
`timescale 1ns/1ps
`default_nettype none
module tb
    import sva_pkg::*;
;
    typedef struct packed {
        logic [3:0]  key;
        logic [7:0]  code, qual;
        logic [31:0] ptr;
    } sva_row_s;
    logic        core_clk, rst_n;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    int          errorCnt = 0, checksDone = 0, n;
    logic        ill;
    logic [31:0] ptrExp;
    sva_row_s    rows [6] = '{
        '{KEY_NREADY, 8'h04, 8'h01, 32'h0000_0000},
        '{KEY_HW, 8'h44, 8'h00, 32'h0001_004a},
        '{KEY_ILLEGAL, 8'h24, 8'h00, 32'h0003_004f},
        '{KEY_ILLEGAL, 8'h26, 8'h02, 32'h0007_0000},
        '{KEY_ATTN, 8'h28, 8'h00, 32'h0000_0000},
        '{KEY_ABORT, 8'h47, 8'h03, 32'h0000_0000}};
    sva_core sva_core_inst (.*);
    sva_mst sva_mst_inst (.*);
    // ********
    // Helpers
    // ********
    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    function automatic logic [31:0] sense(input logic [3:0] k,
                                          input logic [7:0] c, q);
        return {ERR_CURRENT, 4'h0, k, c, q};
    endfunction
    task automatic chk(input logic [31:0] seen, exp);
        checksDone++;
        if (seen !== exp)
        begin
            errorCnt++;
            $display("CHECK FAILED t=%0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic reportAndStop();
        $display("checks %0d mismatches %0d", checksDone, errorCnt);
        if (errorCnt == 0 && checksDone > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        sva_mst_inst.wr(a, v, r);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] m, e);
        sva_mst_inst.rd(a, d, r);
        chk(d & m, e & m);
    endtask
    // A scan that never ends is caught by the state check after the poll.
    task automatic report(input logic [7:0] b1, input logic [15:0] st, cnt,
                          input logic [23:0] len, input logic [4:0] act);
        wr(REG_CMD, {cnt[15:8], st, b1});
        wr(REG_ALLOC, {cnt[7:0], len});
        wr(REG_CTRL, {19'h0, act, 8'h02});
        n = 0;
        do
            sva_mst_inst.rd(REG_STAT, d, r);
        while (d[1:0] !== 2'h2 && n++ < 40);
        chk({30'h0, d[1:0]}, 32'h2);
    endtask
    // Far above the few hundred cycles the tests need.
    initial
    begin
        #(100 * 30000);
        errorCnt++;
        reportAndStop();
    end
    // ********
    // Tests
    // ********
    initial
    begin
        rst_n = 1'b0;
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        rchk(REG_SENSE, 32'hfff0_0000, sense(KEY_ATTN, 8'h0, 8'h0));
        rchk(REG_SENSE, 32'hfff0_0000, 32'h0);
        $display("reset test done");
        foreach (rows[i])
        begin
            wr(REG_ERR, {8'h0, rows[i].qual, rows[i].code, 4'h0, rows[i].key});
            wr(REG_PTR, rows[i].ptr);
            ill = (rows[i].key == KEY_ILLEGAL);
            ptrExp = {rows[i].ptr[31:16], 8'h0, ill, rows[i].ptr[6] & ill,
                      2'b0, rows[i].ptr[3] & ill, rows[i].ptr[2:0]};
            rchk(REG_PTR, 32'hffff_00ff, ptrExp);
            rchk(REG_SENSE, '1, sense(rows[i].key, rows[i].code, rows[i].qual));
            chk({30'h0, r}, {30'h0, RESP_OKAY});
            rchk(REG_SENSE, 32'hfff0_0000, 32'h0);
        end
        $display("sense rows test done");
        wr(REG_CTRL, 32'h0000_0004);
        wr(REG_ERR, {28'h0, KEY_HW});
        sva_mst_inst.rd(REG_SENSE, d, r);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        rchk(REG_STAT, 32'h20, 32'h20);
        wr(REG_CTRL, 32'h0);
        rchk(REG_SENSE, 32'hfff0_0000, sense(KEY_HW, 8'h0, 8'h0));
        $display("fatal sense test done");
        wr(REG_CTRL, {19'h0, ACT_TRANSLATE, 8'h08});
        wr(REG_MATCH, 32'h0000_0a50);
        report(8'h00, 16'h5, 16'h2, 24'h64, ACT_TRANSLATE);
        rchk(REG_RPT, 32'hffff_00ff, {16'h2, 8'h0, ADD_LEN});
        rchk(REG_HDR0, '1, 32'h0002_0006);
        rchk(REG_HDR1, '1, {24'd24, 3'h0, ACT_TRANSLATE});
        rchk(REG_MATCH, '1, 32'h0000_0810);
        report(8'h10, 16'h0, 16'h5, 24'd42, ACT_TRANSLATE);
        rchk(REG_RPT, 32'hffff_0000, 32'h0001_0000);
        rchk(REG_MATCH, '1, 32'h0000_0800);
        report(8'h00, 16'h0, 16'h5, 24'h0, ACT_TRANSLATE);
        rchk(REG_RPT, 32'hffff_0000, 32'h0);
        $display("report test done");
        wr(REG_CTRL, 32'h0000_0108);
        report(8'h00, 16'h0, 16'h5, 24'h64, 5'h01);
        rchk(REG_SENSE, '1, sense(KEY_ILLEGAL, CODE_SEQ, QUAL_SEQ));
        @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        rchk(REG_SENSE, 32'hfff0_0000, sense(KEY_ATTN, 8'h0, 8'h0));
        report(8'h00, 16'h0, 16'h5, 24'h64, ACT_TRANSLATE);
        rchk(REG_STAT, 32'h4, 32'h4);
        rchk(REG_SENSE, '1, sense(KEY_ILLEGAL, CODE_SEQ, QUAL_SEQ));
        $display("sequence test done");
        rchk(8'h3c, '1, 32'h0);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        sva_mst_inst.wr(8'h3c, 32'h1234_5678, r);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        $display("unmapped test done");
        reportAndStop();
    end
endmodule // tb
`default_nettype wire
